// File: verilog/pstrap_capture.sv
`timescale 1ns/100ps
`default_nettype none

`include "pstrap_defines.svh"

module pstrap_capture (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rstn_in,
  // external reset pin
  input  wire logic       ext_reset_n_in,
  // receive data pins
  input  wire logic [3:0] rxd_pin_in,
  output logic      [3:0] rxd_pin_out,
  output logic      [3:0] rxd_pin_oe_n_out,
  // receive clock pin
  input  wire logic       rxclk_pin_in,
  output logic            rxclk_pin_out,
  output logic            rxclk_pin_oe_n_out,
  // collision / carrier sense data valid pin
  input  wire logic       col_pin_in,
  output logic            col_pin_out,
  output logic            col_pin_oe_n_out,
  // interrupt / transmit error / transmit bit 4 pin
  input  wire logic       irq_pin_in,
  output logic            irq_pin_out,
  output logic            irq_pin_oe_n_out,
  // core side receive signals to the pins
  input  wire logic [3:0] rx_data_in,
  input  wire logic       rx_clk_in,
  input  wire logic       collision_in,
  input  wire logic       crs_dv_in,
  // core side interrupt and transmit controls
  input  wire logic       irq_event_in,
  input  wire logic       five_b_mode_in,
  // transmit signals from the shared pin
  output logic            tx_error_out,
  output logic            tx_bit4_out,
  // captured configuration
  output logic      [2:0] op_config_out,
  output logic            regulator_disable_out,
  output logic            rmii_mode_out,
  output logic            irq_pin_mode_out,
  output logic            config_valid_out,
  output logic            device_in_reset_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pstrap_pkg::pstrap_state_t state;
    logic                      ext_prev;
    pstrap_pkg::pstrap_cfg_t   cfg;
    pstrap_pkg::pstrap_pins_t  pins;
    logic                      tx_error;
    logic                      tx_bit4;
    logic                      in_reset;
  } pstrap_st_t;

  pstrap_st_t                     st_r;
  pstrap_st_t                     st_nxt;
  logic [`PSTRAP_SYNC_W-1:0]      pin_raw;
  logic [`PSTRAP_SYNC_W-1:0]      pin_lvl;
  logic                           ext_lvl;
  logic                           ext_rise;
  logic                           run;
  logic                           int_mode;
  logic                           pins_on;
  logic                           irq_pull;
  logic                           tx_in;
  pstrap_pkg::pstrap_cfg_t        strap_now;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {irq_pin_in, col_pin_in, rxclk_pin_in, rxd_pin_in, ext_reset_n_in};

  pstrap_sync #(
    .W (`PSTRAP_SYNC_W)
  ) u_sync (
    .clock_in  (clock_in),
    .rstn_in   (rstn_in),
    .async_in  (pin_raw),
    .level_out (pin_lvl)
  );

  assign ext_lvl  = pin_lvl[`PSTRAP_POS_EXT_RST];
  assign ext_rise = ext_lvl & ~st_r.ext_prev;
  assign run      = (st_r.state == pstrap_pkg::PSTRAP_ST_RUN);
  assign int_mode = (st_r.cfg.irq_pin_select_strap == `PSTRAP_IRQ_SEL_INT);

  // ----------------------------------------------------------------
  // strap levels, filtered to the same depth as the reset pin
  // ----------------------------------------------------------------
  assign strap_now = '{
    op_config:            pin_lvl[`PSTRAP_POS_RXD_LO+:`PSTRAP_MODE_W],
    regulator_disable:    pin_lvl[`PSTRAP_POS_RXCLK],
    rmii_mode:            pin_lvl[`PSTRAP_POS_COL],
    irq_pin_select_strap: pin_lvl[`PSTRAP_POS_RXD3]
  };

  // ----------------------------------------------------------------
  // pin ownership
  // ----------------------------------------------------------------
  // pins are handed back on the same edge that the filtered reset low is seen
  assign pins_on  = run & ext_lvl;
  assign irq_pull = int_mode & irq_event_in;
  assign tx_in    = run & ~int_mode & pin_lvl[`PSTRAP_POS_IRQ];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.ext_prev = ext_lvl;
    st_nxt.in_reset = ~ext_lvl;
    case (st_r.state)
      pstrap_pkg::PSTRAP_ST_HOLD: begin
        if (ext_rise) begin
          st_nxt.cfg   = strap_now;
          st_nxt.state = pstrap_pkg::PSTRAP_ST_RUN;
        end
      end
      pstrap_pkg::PSTRAP_ST_RUN: begin
        // configuration is only rewritten on the next release
        if (!ext_lvl) begin
          st_nxt.state = pstrap_pkg::PSTRAP_ST_HOLD;
        end
      end
      default: begin
        st_nxt.state = pstrap_pkg::PSTRAP_ST_HOLD;
      end
    endcase

    // ----------------------------------------------------------------
    // receive side pin drive
    // ----------------------------------------------------------------
    st_nxt.pins.rxd_out   = rx_data_in;
    st_nxt.pins.rxclk_out = rx_clk_in;
    st_nxt.pins.col_out   = st_r.cfg.rmii_mode ? crs_dv_in : collision_in;
    st_nxt.pins.irq_out   = 1'h0;
    if (pins_on) begin
      st_nxt.pins.rxd_oe_n   = {`PSTRAP_RXD_W{`PSTRAP_OE_ON}};
      st_nxt.pins.rxclk_oe_n = `PSTRAP_OE_ON;
      st_nxt.pins.col_oe_n   = `PSTRAP_OE_ON;
      // open drain: low while an event is pending in interrupt mode, released otherwise
      st_nxt.pins.irq_oe_n   = irq_pull ? `PSTRAP_OE_ON : `PSTRAP_OE_OFF;
    end else begin
      st_nxt.pins.rxd_oe_n   = {`PSTRAP_RXD_W{`PSTRAP_OE_OFF}};
      st_nxt.pins.rxclk_oe_n = `PSTRAP_OE_OFF;
      st_nxt.pins.col_oe_n   = `PSTRAP_OE_OFF;
      st_nxt.pins.irq_oe_n   = `PSTRAP_OE_OFF;
    end

    // ----------------------------------------------------------------
    // shared pin as transmit input
    // ----------------------------------------------------------------
    st_nxt.tx_error = tx_in & ~five_b_mode_in;
    st_nxt.tx_bit4  = tx_in & five_b_mode_in;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r.state           <= pstrap_pkg::PSTRAP_ST_HOLD;
      st_r.ext_prev        <= 1'h0;
      st_r.cfg             <= `PSTRAP_CFG_RST;
      st_r.pins.rxd_out    <= `PSTRAP_RXD_RST;
      st_r.pins.rxd_oe_n   <= {`PSTRAP_RXD_W{`PSTRAP_OE_OFF}};
      st_r.pins.rxclk_out  <= 1'h0;
      st_r.pins.rxclk_oe_n <= `PSTRAP_OE_OFF;
      st_r.pins.col_out    <= 1'h0;
      st_r.pins.col_oe_n   <= `PSTRAP_OE_OFF;
      st_r.pins.irq_out    <= 1'h0;
      st_r.pins.irq_oe_n   <= `PSTRAP_OE_OFF;
      st_r.tx_error        <= 1'h0;
      st_r.tx_bit4         <= 1'h0;
      st_r.in_reset        <= 1'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rxd_pin_out           = st_r.pins.rxd_out;
  assign rxd_pin_oe_n_out      = st_r.pins.rxd_oe_n;
  assign rxclk_pin_out         = st_r.pins.rxclk_out;
  assign rxclk_pin_oe_n_out    = st_r.pins.rxclk_oe_n;
  assign col_pin_out           = st_r.pins.col_out;
  assign col_pin_oe_n_out      = st_r.pins.col_oe_n;
  assign irq_pin_out           = st_r.pins.irq_out;
  assign irq_pin_oe_n_out      = st_r.pins.irq_oe_n;
  assign tx_error_out          = st_r.tx_error;
  assign tx_bit4_out           = st_r.tx_bit4;

  // ----------------------------------------------------------------
  // captured configuration outputs
  // ----------------------------------------------------------------
  assign op_config_out         = st_r.cfg.op_config;
  assign regulator_disable_out = st_r.cfg.regulator_disable;
  assign rmii_mode_out         = st_r.cfg.rmii_mode;
  assign irq_pin_mode_out      = st_r.cfg.irq_pin_select_strap;
  assign config_valid_out      = run;
  assign device_in_reset_out   = st_r.in_reset;

endmodule : pstrap_capture

`default_nettype wire

// File: pkg/pstrap_defines.svh
`ifndef PSTRAP_DEFINES_SVH
`define PSTRAP_DEFINES_SVH

// ----------------------------------------------------------------
// positions in the synchronised pin vector
// ----------------------------------------------------------------
`define PSTRAP_SYNC_W        8
`define PSTRAP_POS_EXT_RST   0
`define PSTRAP_POS_RXD_LO    1
`define PSTRAP_POS_RXD_HI    4
`define PSTRAP_POS_RXD3      4
`define PSTRAP_POS_RXCLK     5
`define PSTRAP_POS_COL       6
`define PSTRAP_POS_IRQ       7

// ----------------------------------------------------------------
// widths and levels
// ----------------------------------------------------------------
`define PSTRAP_RXD_W         4
`define PSTRAP_MODE_W        3
`define PSTRAP_SYNC_RST      8'h00
`define PSTRAP_CFG_RST       6'h00
`define PSTRAP_RXD_RST       4'h0
`define PSTRAP_OE_OFF        1'h1
`define PSTRAP_OE_ON         1'h0
`define PSTRAP_IRQ_SEL_INT   1'h1

`endif

// File: pkg/pstrap_pkg.sv
package pstrap_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    PSTRAP_ST_HOLD,
    PSTRAP_ST_RUN
  } pstrap_state_t;

  // ----------------------------------------------------------------
  // captured configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] op_config;
    logic       regulator_disable;
    logic       rmii_mode;
    logic       irq_pin_select_strap;
  } pstrap_cfg_t;

  // ----------------------------------------------------------------
  // drive of the shared pins
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rxd_out;
    logic [3:0] rxd_oe_n;
    logic       rxclk_out;
    logic       rxclk_oe_n;
    logic       col_out;
    logic       col_oe_n;
    logic       irq_out;
    logic       irq_oe_n;
  } pstrap_pins_t;

endpackage : pstrap_pkg

// File: verilog/pstrap_sync.sv
`timescale 1ns/100ps
`default_nettype none

`include "pstrap_defines.svh"

module pstrap_sync #(
  parameter int W = `PSTRAP_SYNC_W
) (
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  // pins in, filtered level out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } pstrap_sync_st_t;

  pstrap_sync_st_t st_r;
  pstrap_sync_st_t st_nxt;
  logic [W-1:0]    agree;

  // ----------------------------------------------------------------
  // three stages; a level is taken once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    agree      = st_r.s2 ~^ st_r.s3;
    st_nxt.s1  = async_in;
    st_nxt.s2  = st_r.s1;
    st_nxt.s3  = st_r.s2;
    st_nxt.lvl = (agree & st_r.s2) | (~agree & st_r.lvl);
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.lvl;

endmodule : pstrap_sync

`default_nettype wire

// File: testbench/pstrap_capture_props.sv
`timescale 1ns/100ps
`default_nettype none

module pstrap_capture_props (
  // clock and reset
  input wire logic       clock_in,
  input wire logic       rstn_in,
  // pins and core inputs
  input wire logic       ext_reset_n_in,
  input wire logic [3:0] rxd_pin_in,
  input wire logic       rxclk_pin_in,
  input wire logic       col_pin_in,
  input wire logic       rx_clk_in,
  input wire logic       collision_in,
  input wire logic       crs_dv_in,
  input wire logic       irq_event_in,
  // design outputs
  input wire logic [3:0] rxd_pin_oe_n_out,
  input wire logic       rxclk_pin_out,
  input wire logic       rxclk_pin_oe_n_out,
  input wire logic       col_pin_out,
  input wire logic       col_pin_oe_n_out,
  input wire logic       irq_pin_out,
  input wire logic       irq_pin_oe_n_out,
  input wire logic [2:0] op_config_out,
  input wire logic       regulator_disable_out,
  input wire logic       rmii_mode_out,
  input wire logic       irq_pin_mode_out,
  input wire logic       config_valid_out,
  input wire logic       device_in_reset_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  property p_hold_oe;
    device_in_reset_out && $past(device_in_reset_out) |->
      &{rxd_pin_oe_n_out, rxclk_pin_oe_n_out, col_pin_oe_n_out, irq_pin_oe_n_out};
  endproperty
  a_hold_oe: assert property (p_hold_oe) else $error("pin driven in reset");

  property p_cfg_stable;
    config_valid_out && $past(config_valid_out) |->
      $stable({op_config_out, regulator_disable_out, rmii_mode_out, irq_pin_mode_out});
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config moved");

  property p_capture;
    $rose(config_valid_out) |-> {op_config_out, regulator_disable_out, rmii_mode_out,
      irq_pin_mode_out} == {$past(rxd_pin_in[2:0]), $past(rxclk_pin_in), $past(col_pin_in),
      $past(rxd_pin_in[3])};
  endproperty
  a_capture: assert property (p_capture) else $error("bad capture");

  property p_col_mux;
    config_valid_out && $past(config_valid_out, 2) |-> !col_pin_oe_n_out &&
      col_pin_out == $past(rmii_mode_out ? crs_dv_in : collision_in);
  endproperty
  a_col_mux: assert property (p_col_mux) else $error("collision pin wrong");

  property p_irq_int;
    config_valid_out && $past(config_valid_out, 2) && irq_pin_mode_out |->
      irq_pin_oe_n_out == !$past(irq_event_in) && !irq_pin_out;
  endproperty
  a_irq_int: assert property (p_irq_int) else $error("irq pin wrong");

  property p_irq_tx;
    config_valid_out && $past(config_valid_out, 2) && !irq_pin_mode_out |-> irq_pin_oe_n_out;
  endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("tx pin driven");

  property p_rxclk;
    config_valid_out && $past(config_valid_out, 2) |->
      !rxclk_pin_oe_n_out && rxclk_pin_out == $past(rx_clk_in);
  endproperty
  a_rxclk: assert property (p_rxclk) else $error("rx clock pin wrong");

  property p_ext;
    (!ext_reset_n_in) [*6] |-> device_in_reset_out && !config_valid_out;
  endproperty
  a_ext: assert property (p_ext) else $error("running in reset");
endmodule : pstrap_capture_props

bind pstrap_capture pstrap_capture_props u_props (.clock_in, .rstn_in, .ext_reset_n_in,
  .rxd_pin_in, .rxclk_pin_in, .col_pin_in, .rx_clk_in, .collision_in, .crs_dv_in,
  .irq_event_in, .rxd_pin_oe_n_out, .rxclk_pin_out, .rxclk_pin_oe_n_out, .col_pin_out,
  .col_pin_oe_n_out, .irq_pin_out, .irq_pin_oe_n_out, .op_config_out, .regulator_disable_out,
  .rmii_mode_out, .irq_pin_mode_out, .config_valid_out, .device_in_reset_out);

`default_nettype wire

// File: testbench/pstrap_board.sv
`timescale 1ns/100ps
`default_nettype none

module pstrap_board (
  // device drive and board levels
  input  wire pstrap_pkg::pstrap_pins_t drv_in,
  input  wire logic [6:0]               far_in,
  input  wire logic                     rst_req_in,
  // resolved pins
  output logic      [6:0]               pin_out,
  output logic                          ext_reset_n_out
);
  logic [6:0] oe_n;
  logic [6:0] dout;

  assign oe_n = {drv_in.irq_oe_n, drv_in.col_oe_n, drv_in.rxclk_oe_n, drv_in.rxd_oe_n};
  assign dout = {drv_in.irq_out, drv_in.col_out, drv_in.rxclk_out, drv_in.rxd_out};
  // undriven pins settle to the resistor level
  assign pin_out = (oe_n & far_in) | (~oe_n & dout);
  assign ext_reset_n_out = ~rst_req_in;
endmodule : pstrap_board

`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic       clock_in = 1'h0;
  logic       rstn_in = 1'h0;
  logic       rst_req = 1'h1;
  logic [6:0] far = 7'h00;
  logic [6:0] pin;
  logic [3:0] rx_data_in = 4'h0;
  logic       rx_clk_in = 1'h0, collision_in = 1'h0, crs_dv_in = 1'h0;
  logic       irq_event_in = 1'h0, five_b_mode_in = 1'h0;
  logic       ext_reset_n_in, tx_error_out, tx_bit4_out;
  logic [2:0] op_config_out;
  logic       regulator_disable_out, rmii_mode_out, irq_pin_mode_out;
  logic       config_valid_out, device_in_reset_out;
  wire pstrap_pkg::pstrap_pins_t drv;
  int         seed = 94;
  int         fails = 0;
  int         n_tests = 0;
  int         e;
  int         exp_q[$];

  always #2 clock_in = ~clock_in;

  pstrap_board board (.drv_in(drv), .far_in(far), .rst_req_in(rst_req), .pin_out(pin),
    .ext_reset_n_out(ext_reset_n_in));

  pstrap_capture uut (.clock_in, .rstn_in, .ext_reset_n_in, .rxd_pin_in(pin[3:0]),
    .rxd_pin_out(drv.rxd_out), .rxd_pin_oe_n_out(drv.rxd_oe_n), .rxclk_pin_in(pin[4]),
    .rxclk_pin_out(drv.rxclk_out), .rxclk_pin_oe_n_out(drv.rxclk_oe_n), .col_pin_in(pin[5]),
    .col_pin_out(drv.col_out), .col_pin_oe_n_out(drv.col_oe_n), .irq_pin_in(pin[6]),
    .irq_pin_out(drv.irq_out), .irq_pin_oe_n_out(drv.irq_oe_n), .rx_data_in, .rx_clk_in,
    .collision_in, .crs_dv_in, .irq_event_in, .five_b_mode_in, .tx_error_out, .tx_bit4_out,
    .op_config_out, .regulator_disable_out, .rmii_mode_out, .irq_pin_mode_out,
    .config_valid_out, .device_in_reset_out);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk_cfg();
    chk({op_config_out, regulator_disable_out, rmii_mode_out, irq_pin_mode_out},
        {far[2:0], far[4], far[5], far[3]});
  endtask : chk_cfg

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // strap, capture and traffic passes
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock_in);
    #1 rstn_in = 1'h1;
    for (int it = 0; it < 8; it++) begin
      @(posedge clock_in);
      #1 rst_req = 1'h1;
      far = 7'($random(seed));
      far[3] = it[0];
      far[5] = it[1];
      far[6] = far[3];
      repeat (8) @(posedge clock_in);
      #1 chk({drv.rxd_oe_n, drv.rxclk_oe_n, drv.col_oe_n, drv.irq_oe_n}, 8'h7f);
      chk({device_in_reset_out, config_valid_out}, 8'h02);
      rst_req = 1'h0;
      e = 0;
      while (config_valid_out !== 1'h1 && e < 20) begin
        @(posedge clock_in);
        #1 e++;
      end
      chk({7'h00, config_valid_out}, 8'h01);
      chk_cfg();
      @(posedge clock_in);
      exp_q = {};
      repeat (12) begin
        @(posedge clock_in);
        #1 if (exp_q.size() > 0)
          chk({drv.rxd_out, drv.rxclk_out, drv.col_out, drv.irq_oe_n},
              8'(exp_q.pop_front()));
        chk({drv.rxd_oe_n, drv.rxclk_oe_n, drv.col_oe_n}, 8'h00);
        chk_cfg();
        {rx_data_in, rx_clk_in, collision_in, crs_dv_in, irq_event_in} = 8'($random(seed));
        exp_q.push_back({rx_data_in, rx_clk_in, far[5] ? crs_dv_in : collision_in,
                         ~(far[3] & irq_event_in)});
      end
      for (int k = 0; k < 4; k++) begin
        far[6] = k[0] | far[3];
        five_b_mode_in = k[1];
        repeat (8) @(posedge clock_in);
        #1 chk({tx_error_out, tx_bit4_out},
               {~far[3] & ~k[1] & k[0], ~far[3] & k[1] & k[0]});
      end
    end
    end_of_test();
  end

  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule : tb

`default_nettype wire
